// >>> design/ccm_charger_config_mask_regs.sv
// Charger configuration and mask registers behind an I2C target port
// Functional notes
// [RULE1] Mask bit one suppresses interrupt, resets zero
// [RULE2] Watchdog bit6, timer bit5, overcurrent bit4
// [RULE3] Wake1 bit2, wake2 bit1, reset warning bit0
// [RULE4] Regulation voltage is 3.6V plus code*10mV
// [RULE5] Codes above 4.6V are stored as 4.6V
// [RULE6] Regulation register resets to 0x3C, 4.2V
// [RULE7] Fast current is code times selected step
// [RULE8] Fast current register resets to code 0x8
// [RULE9] Step bit: 0 gives 1.25mA, 1 gives 2.5mA
// [RULE10] Precharge code bits4-0 times step, resets 00010
// [RULE11] Termination code bits5-1, percent, resets 01010
// [RULE12] Host never writes termination code zero
// [RULE13] Bit0 one disables termination, resets zero
// [RULE14] Wake1 flag sets on expiry, cleared by read
// [RULE15] Masked event still flags, no interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ccm_consts.svh"

module ccm_charger_config_mask_regs
  import ccm_pkg::*;
#(
  parameter logic [6:0] I2C_ADDR = 7'h2A
) (
  input  wire logic     i_ref_clk,
  input  wire logic     i_nrst,
  input  wire logic     i_scl,
  input  wire logic     i_sda,
  output var  logic     o_sda_o,
  output var  logic     o_sda_oe,
  input  wire ccm_evt_t i_evt,
  output var  ccm_cfg_t o_cfg,
  output var  logic     o_irq
);

  localparam ccm_state_t RST = '{
    st:      ccm_st_idle,
    scl_q:   1'b1,
    sda_q:   1'b1,
    bitc:    `CCM_BIT_ZERO,
    shf:     8'h00,
    ptr:     8'h00,
    first:   1'b0,
    rw:      1'b0,
    mack:    1'b0,
    sda_oe:  1'b0,
    flags:   `CCM_RST_FLAG,
    mask:    `CCM_RST_MASK,
    vbat:    `CCM_RST_VBAT,
    ichg:    `CCM_RST_ICHG,
    pchg:    `CCM_RST_PCHG,
    term:    `CCM_RST_TERM,
    irq:     1'b0,
    vreg_mv: `CCM_RST_VMV,
    ichg_ua: `CCM_RST_ICHUA,
    pchg_ua: `CCM_RST_PCHUA
  };

  ccm_state_t s;
  ccm_state_t next_s;
  logic [1:0] pins;
  logic       scl;
  logic       sda;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       ld;
  logic       wr_now;
  logic [7:0] rdat;
  logic [7:0] clr;
  logic [7:0] evt_vec;
  logic [6:0] vcode;
  logic [19:0] step;

  ccm_sync2 #(
    .W (2)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_d       ({i_scl, i_sda}),
    .o_q       (pins)
  );

  assign scl   = pins[1];
  assign sda   = pins[0];
  assign rise  = scl & ~s.scl_q;
  assign fall  = ~scl & s.scl_q;
  assign start = scl & s.scl_q & s.sda_q & ~sda;
  assign stop  = scl & s.scl_q & ~s.sda_q & sda;

  always_comb
  begin
    next_s  = s;
    ld      = 1'b0;
    wr_now  = 1'b0;
    clr     = 8'h00;
    evt_vec = 8'h00;
    vcode   = s.shf[`CCM_VBAT_MSB:0];
    evt_vec[`CCM_B_WD]   = i_evt.watchdog_fault;
    evt_vec[`CCM_B_TMR]  = i_evt.charge_timer_fault;
    evt_vec[`CCM_B_OCP]  = i_evt.regulator_overcurrent;
    evt_vec[`CCM_B_WK1]  = i_evt.button_wake_first;     // [RULE14]
    evt_vec[`CCM_B_WK2]  = i_evt.button_wake_second;
    evt_vec[`CCM_B_RSTW] = i_evt.button_reset_warning;
    case (s.ptr)
      `CCM_OFF_FLAG: rdat = s.flags;
      `CCM_OFF_MASK: rdat = s.mask;
      `CCM_OFF_VBAT: rdat = s.vbat;
      `CCM_OFF_ICHG: rdat = s.ichg;
      `CCM_OFF_PCHG: rdat = s.pchg;
      `CCM_OFF_TERM: rdat = s.term;
      default:       rdat = 8'h00;
    endcase
    next_s.scl_q = scl;
    next_s.sda_q = sda;
    if (start)
    begin
      next_s.st     = ccm_st_addr;
      next_s.bitc   = `CCM_BIT_ZERO;
      next_s.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      next_s.st     = ccm_st_idle;
      next_s.sda_oe = 1'b0;
    end
    else
    begin
      unique case (s.st)
        ccm_st_idle: ;
        ccm_st_addr, ccm_st_wr:
        begin
          if (rise)
          begin
            next_s.shf  = {s.shf[6:0], sda};
            next_s.bitc = s.bitc + `CCM_BIT_ONE;
          end
          else if (fall && s.bitc == `CCM_BYTE_BITS)
          begin
            if (s.st == ccm_st_addr)
            begin
              if (s.shf[7:1] == I2C_ADDR)
              begin
                next_s.sda_oe = 1'b1;
                next_s.rw     = s.shf[0];
                next_s.first  = 1'b1;
                next_s.st     = ccm_st_aack;
              end
              else
                next_s.st = ccm_st_idle;
            end
            else
            begin
              next_s.sda_oe = 1'b1;
              next_s.st     = ccm_st_wack;
              if (s.first)
              begin
                next_s.ptr   = s.shf;
                next_s.first = 1'b0;
              end
              else
              begin
                wr_now     = 1'b1;
                next_s.ptr = s.ptr + 8'h01;
              end
            end
          end
        end
        ccm_st_aack:
        begin
          if (fall)
          begin
            if (s.rw)
              ld = 1'b1;
            else
            begin
              next_s.sda_oe = 1'b0;
              next_s.bitc   = `CCM_BIT_ZERO;
              next_s.st     = ccm_st_wr;
            end
          end
        end
        ccm_st_wack:
        begin
          if (fall)
          begin
            next_s.sda_oe = 1'b0;
            next_s.bitc   = `CCM_BIT_ZERO;
            next_s.st     = ccm_st_wr;
          end
        end
        ccm_st_rd:
        begin
          if (fall)
          begin
            if (s.bitc == `CCM_BYTE_BITS)
            begin
              next_s.sda_oe = 1'b0;
              next_s.st     = ccm_st_rack;
            end
            else
            begin
              next_s.sda_oe = ~s.shf[6];
              next_s.shf    = {s.shf[6:0], 1'b0};
              next_s.bitc   = s.bitc + `CCM_BIT_ONE;
            end
          end
        end
        ccm_st_rack:
        begin
          if (rise)
            next_s.mack = ~sda;
          else if (fall)
          begin
            if (s.mack)
              ld = 1'b1;
            else
              next_s.st = ccm_st_idle;
          end
        end
        default: next_s.st = ccm_st_idle;
      endcase
    end
    if (ld)
    begin
      next_s.shf    = rdat;
      next_s.sda_oe = ~rdat[7];
      next_s.bitc   = `CCM_BIT_ONE;
      next_s.ptr    = s.ptr + 8'h01;
      next_s.st     = ccm_st_rd;
      if (s.ptr == `CCM_OFF_FLAG)
        clr = 8'hFF;                                    // [RULE14]
    end
    if (wr_now)
    begin
      case (s.ptr)
        `CCM_OFF_MASK: next_s.mask = s.shf;             // [RULE2] [RULE3]
        `CCM_OFF_VBAT:
        begin
          if (vcode > `CCM_VREG_MAX)
            vcode = `CCM_VREG_MAX;                      // [RULE5]
          next_s.vbat = {s.shf[7], vcode};
        end
        `CCM_OFF_ICHG: next_s.ichg = s.shf;
        `CCM_OFF_PCHG: next_s.pchg = s.shf;
        `CCM_OFF_TERM: next_s.term = s.shf;             // [RULE11] [RULE13]
        default: ;
      endcase
    end
    // A new event wins over a read-clear in the same cycle
    next_s.flags = (s.flags & ~clr) | (evt_vec & `CCM_EVT_VALID); // [RULE15]
    next_s.irq = |(next_s.flags & ~next_s.mask & `CCM_EVT_VALID); // [RULE1]
    step = s.pchg[`CCM_B_STEP] ? `CCM_STEP_WIDE : `CCM_STEP_FINE; // [RULE9]
    next_s.vreg_mv = `CCM_VREG_BASE
                   + 13'(s.vbat[`CCM_VBAT_MSB:0]) * `CCM_VREG_STEP; // [RULE4]
    next_s.ichg_ua = 20'(s.ichg) * step;                // [RULE7]
    next_s.pchg_ua = 20'(s.pchg[`CCM_PCHG_MSB:0]) * step; // [RULE10]
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      s <= RST;                           // [RULE6] [RULE8] [RULE10]
    else
      s <= next_s;
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = s.sda_oe;
  assign o_irq    = s.irq;

  always_comb
  begin
    o_cfg = '0;
    o_cfg.watchdog_fault_irq_mask        = s.mask[`CCM_B_WD];
    o_cfg.charge_timer_fault_irq_mask    = s.mask[`CCM_B_TMR];
    o_cfg.regulator_overcurrent_irq_mask = s.mask[`CCM_B_OCP];
    o_cfg.button_wake_first_irq_mask     = s.mask[`CCM_B_WK1];
    o_cfg.button_wake_second_irq_mask    = s.mask[`CCM_B_WK2];
    o_cfg.button_reset_warning_irq_mask  = s.mask[`CCM_B_RSTW];
    o_cfg.button_wake_first_flag         = s.flags[`CCM_B_WK1];
    o_cfg.regulation_voltage_target      = s.vreg_mv;
    o_cfg.fast_charge_current_code       = s.ichg;
    o_cfg.programmed_charge_current      = s.ichg_ua;
    o_cfg.current_step_select            = s.pchg[`CCM_B_STEP];
    o_cfg.precharge_current_code         = s.pchg[`CCM_PCHG_MSB:0];
    o_cfg.precharge_current              = s.pchg_ua;
    o_cfg.termination_percent_code = s.term[`CCM_TERM_MSB:`CCM_TERM_LSB];
    o_cfg.termination_disable            = s.term[`CCM_B_TDIS];
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_vbat_high_wr;
    wr_now && s.ptr == `CCM_OFF_VBAT
      && s.shf[`CCM_VBAT_MSB:0] > `CCM_VREG_MAX;
  endsequence
  sequence s_vbat_clamped;
    s.vbat[`CCM_VBAT_MSB:0] == `CCM_VREG_MAX;
  endsequence

  property p_reset_vals;
    $rose(i_nrst) |-> s.mask == `CCM_RST_MASK && s.vbat == `CCM_RST_VBAT
      && s.ichg == `CCM_RST_ICHG && s.pchg == `CCM_RST_PCHG
      && s.term == `CCM_RST_TERM && !o_irq;
  endproperty
  a_reset_vals: assert property (p_reset_vals) // [RULE6] [RULE8] [RULE13]
    else $error("register reset value wrong");

  property p_irq_gate;
    o_irq == |(s.flags & ~s.mask & `CCM_EVT_VALID);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [RULE1] [RULE15]
    else $error("interrupt does not follow flags and mask");

  property p_masked_evt_flag;
    i_evt.watchdog_fault && s.mask[`CCM_B_WD] && !wr_now
      |=> s.flags[`CCM_B_WD];
  endproperty
  a_masked_evt_flag: assert property (p_masked_evt_flag) // [RULE15]
    else $error("masked event did not set its flag");

  property p_evt_flag;
    i_evt.button_wake_first |=> s.flags[`CCM_B_WK1] ##0 o_cfg.button_wake_first_flag;
  endproperty
  a_evt_flag: assert property (p_evt_flag) // [RULE14]
    else $error("wake flag not set by event");

  property p_rd_clear;
    ld && s.ptr == `CCM_OFF_FLAG && evt_vec == 8'h00
      |=> s.flags == 8'h00 && s.shf == $past(s.flags);
  endproperty
  a_rd_clear: assert property (p_rd_clear) // [RULE14]
    else $error("flag read did not return and clear");

  property p_vreg_clamp;
    s_vbat_high_wr |=> s_vbat_clamped;
  endproperty
  a_vreg_clamp: assert property (p_vreg_clamp) // [RULE5]
    else $error("regulation code not clamped");

  property p_vreg_bound;
    s.vbat[`CCM_VBAT_MSB:0] <= `CCM_VREG_MAX;
  endproperty
  a_vreg_bound: assert property (p_vreg_bound) // [RULE5]
    else $error("regulation code above limit");

  property p_vreg_mv;
    ##1 s.vreg_mv == `CCM_VREG_BASE
      + 13'($past(s.vbat[`CCM_VBAT_MSB:0])) * `CCM_VREG_STEP;
  endproperty
  a_vreg_mv: assert property (p_vreg_mv) // [RULE4]
    else $error("regulation voltage mismatch");

  property p_ichg_ua;
    ##1 s.ichg_ua == 20'($past(s.ichg)) * ($past(s.pchg[`CCM_B_STEP])
      ? `CCM_STEP_WIDE : `CCM_STEP_FINE);
  endproperty
  a_ichg_ua: assert property (p_ichg_ua) // [RULE7] [RULE9]
    else $error("fast charge current mismatch");

  property p_pchg_ua;
    ##1 s.pchg_ua == 20'($past(s.pchg[`CCM_PCHG_MSB:0]))
      * ($past(s.pchg[`CCM_B_STEP]) ? `CCM_STEP_WIDE : `CCM_STEP_FINE);
  endproperty
  a_pchg_ua: assert property (p_pchg_ua) // [RULE10]
    else $error("precharge current mismatch");

  property p_mask_store;
    wr_now && s.ptr == `CCM_OFF_MASK |=> s.mask == $past(s.shf);
  endproperty
  a_mask_store: assert property (p_mask_store) // [RULE2] [RULE3]
    else $error("mask write not stored");

  property p_term_store;
    wr_now && s.ptr == `CCM_OFF_TERM |=> s.term == $past(s.shf);
  endproperty
  a_term_store: assert property (p_term_store) // [RULE11] [RULE13]
    else $error("termination write not stored");

endmodule

`default_nettype wire

// >>> design/ccm_consts.svh
// Constants of the charger configuration and mask register bank
`ifndef CCM_CONSTS_SVH
`define CCM_CONSTS_SVH

// Register offsets
`define CCM_OFF_FLAG   8'h06
`define CCM_OFF_MASK   8'h0A
`define CCM_OFF_VBAT   8'h12
`define CCM_OFF_ICHG   8'h13
`define CCM_OFF_PCHG   8'h14
`define CCM_OFF_TERM   8'h15

// Reset values
`define CCM_RST_FLAG   8'h00
`define CCM_RST_MASK   8'h00
`define CCM_RST_VBAT   8'h3C
`define CCM_RST_ICHG   8'h08
`define CCM_RST_PCHG   8'h02
`define CCM_RST_TERM   8'h14
`define CCM_RST_VMV    13'h1068
`define CCM_RST_ICHUA  20'h02710
`define CCM_RST_PCHUA  20'h009C4

// Mask and flag bit positions
`define CCM_B_WD       6
`define CCM_B_TMR      5
`define CCM_B_OCP      4
`define CCM_B_WK1      2
`define CCM_B_WK2      1
`define CCM_B_RSTW     0
`define CCM_EVT_VALID  8'h77

// Field positions
`define CCM_VBAT_MSB   6
`define CCM_B_STEP     7
`define CCM_PCHG_MSB   4
`define CCM_TERM_MSB   5
`define CCM_TERM_LSB   1
`define CCM_B_TDIS     0

// Scaling, in mV and uA
`define CCM_VREG_BASE  13'h0E10
`define CCM_VREG_STEP  13'h000A
`define CCM_VREG_MAX   7'h64
`define CCM_STEP_FINE  20'h004E2
`define CCM_STEP_WIDE  20'h009C4

// Serial link
`define CCM_BYTE_BITS  4'h8
`define CCM_BIT_ONE    4'h1
`define CCM_BIT_ZERO   4'h0

`endif

// >>> design/ccm_pkg.sv
// Types of the charger configuration and mask register bank
`default_nettype none

package ccm_pkg;

  // Serial target engine states; code 3'b111 is unused
  typedef enum logic [2:0] {
    ccm_st_idle = 3'b000,
    ccm_st_addr = 3'b001,
    ccm_st_aack = 3'b010,
    ccm_st_wr   = 3'b011,
    ccm_st_wack = 3'b100,
    ccm_st_rd   = 3'b101,
    ccm_st_rack = 3'b110
  } ccm_i2c_st_t;

  // One bit per interrupt source, high in each cycle the event is seen
  typedef struct packed {
    logic watchdog_fault;
    logic charge_timer_fault;
    logic regulator_overcurrent;
    logic button_wake_first;
    logic button_wake_second;
    logic button_reset_warning;
  } ccm_evt_t;

  // Settings toward the charger; voltage in mV, currents in uA
  typedef struct packed {
    logic        watchdog_fault_irq_mask;
    logic        charge_timer_fault_irq_mask;
    logic        regulator_overcurrent_irq_mask;
    logic        button_wake_first_irq_mask;
    logic        button_wake_second_irq_mask;
    logic        button_reset_warning_irq_mask;
    logic        button_wake_first_flag;
    logic [12:0] regulation_voltage_target;
    logic [7:0]  fast_charge_current_code;
    logic [19:0] programmed_charge_current;
    logic        current_step_select;
    logic [4:0]  precharge_current_code;
    logic [19:0] precharge_current;
    logic [4:0]  termination_percent_code;
    logic        termination_disable;
  } ccm_cfg_t;

  typedef struct packed {
    ccm_i2c_st_t st;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  bitc;
    logic [7:0]  shf;
    logic [7:0]  ptr;
    logic        first;
    logic        rw;
    logic        mack;
    logic        sda_oe;
    logic [7:0]  flags;
    logic [7:0]  mask;
    logic [7:0]  vbat;
    logic [7:0]  ichg;
    logic [7:0]  pchg;
    logic [7:0]  term;
    logic        irq;
    logic [12:0] vreg_mv;
    logic [19:0] ichg_ua;
    logic [19:0] pchg_ua;
  } ccm_state_t;

endpackage

`default_nettype wire

// >>> design/ccm_sync2.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module ccm_sync2 #(
  parameter int W = 2
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_d,
  output var  logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ccm_sync_t;

  ccm_sync_t s;
  ccm_sync_t next_s;

  always_comb
  begin
    next_s.s1 = i_d;
    next_s.s2 = s.s1;
  end

  // Idle bus lines are high
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      s <= '1;
    else
      s <= next_s;
  end

  assign o_q = s.s2;

endmodule

`default_nettype wire

// >>> test/ccm_i2c_host.sv
// I2C host model driving the register port of the charger bank
`timescale 1ns/1ps
`default_nettype none

module ccm_i2c_host #(
  parameter int Q = 5
) (
  input  wire logic i_ref_clk,
  input  wire logic i_sda_o,
  input  wire logic i_sda_oe,
  output var  logic o_scl,
  output var  logic o_sda
);
  logic pull = 1'b0;
  // Open drain with pull-up: a released line reads high
  assign o_sda = !(pull || (i_sda_oe && !i_sda_o));
  initial o_scl = 1'b1;

  task automatic wt();
    repeat (Q) @(negedge i_ref_clk);
  endtask

  // SDA moves only while SCL is low, except for START and STOP
  task automatic start();
    pull = 1'b0;
    wt();
    o_scl = 1'b1;
    wt();
    pull = 1'b1;
    wt();
    o_scl = 1'b0;
    wt();
  endtask

  task automatic stop();
    pull = 1'b1;
    wt();
    o_scl = 1'b1;
    wt();
    pull = 1'b0;
    wt();
  endtask

  task automatic bit_x(input logic b, output logic r);
    pull = !b;
    wt();
    o_scl = 1'b1;
    wt();
    r = o_sda;
    wt();
    o_scl = 1'b0;
    wt();
  endtask

  // MSB first, then the acknowledge slot
  task automatic byte_x(input logic [7:0] d, input logic a,
                        output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], r[i]);
    end
    bit_x(a, ack);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] p, d,
                    output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2;
    start();
    byte_x({a, 1'b0}, 1'b1, r, a0);
    byte_x(p, 1'b1, r, a1);
    byte_x(d, 1'b1, r, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask

  // Pointer write, repeated START, one byte read ended by NACK
  task automatic rd(input logic [7:0] p, output logic [7:0] d,
                    output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2, a3;
    start();
    byte_x(8'h54, 1'b1, r, a0);
    byte_x(p, 1'b1, r, a1);
    start();
    byte_x(8'h55, 1'b1, r, a2);
    byte_x(8'hFF, 1'b1, d, a3);
    stop();
    ok = !(a0 | a1 | a2);
  endtask

  // Two-byte read: first byte acknowledged, second ended by NACK
  task automatic rd2(input logic [7:0] p, output logic [7:0] d0, d1,
                     output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2, a3;
    start();
    byte_x(8'h54, 1'b1, r, a0);
    byte_x(p, 1'b1, r, a1);
    start();
    byte_x(8'h55, 1'b1, r, a2);
    byte_x(8'hFF, 1'b0, d0, a3);
    byte_x(8'hFF, 1'b1, d1, a3);
    stop();
    ok = !(a0 | a1 | a2);
  endtask

  // Two data bytes in one write, stored at rising offsets
  task automatic wr2(input logic [7:0] p, d0, d1, output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2, a3;
    start();
    byte_x(8'h54, 1'b1, r, a0);
    byte_x(p, 1'b1, r, a1);
    byte_x(d0, 1'b1, r, a2);
    byte_x(d1, 1'b1, r, a3);
    stop();
    ok = !(a0 | a1 | a2 | a3);
  endtask
endmodule

`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the charger configuration and mask registers
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import ccm_pkg::*;
;
  localparam logic [7:0] OFF [5] = '{8'h0A, 8'h12, 8'h13, 8'h14, 8'h15};
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       scl, sda, sda_o, sda_oe, irq, ok;
  ccm_evt_t   evt = '0;
  ccm_cfg_t   cfg;
  int         n_fail = 0;
  int         checks_done = 0;
  int         seed = 32'h2544;
  logic [7:0] rv;
  logic [7:0] sh [5] = '{8'h00, 8'h3C, 8'h08, 8'h02, 8'h14};

  always #20 clk = !clk;

  ccm_charger_config_mask_regs u_ccm_charger_config_mask_regs (
    .i_ref_clk(clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_evt(evt), .o_cfg(cfg),
    .o_irq(irq));
  ccm_i2c_host u_ccm_i2c_host (.i_ref_clk(clk), .i_sda_o(sda_o),
    .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));

  task automatic chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  function automatic logic [7:0] stored(int k, logic [7:0] d);
    if (k == 1 && d[6:0] > 7'h64)
      return {d[7], 7'h64};
    return d;
  endfunction

  task automatic chk_cfg();
    logic [31:0] st;
    logic [5:0]  mk;
    st = sh[3][7] ? 2500 : 1250;
    mk = {cfg.watchdog_fault_irq_mask,
          cfg.charge_timer_fault_irq_mask,
          cfg.regulator_overcurrent_irq_mask,
          cfg.button_wake_first_irq_mask,
          cfg.button_wake_second_irq_mask,
          cfg.button_reset_warning_irq_mask};
    chk(mk, {sh[0][6:4], sh[0][2:0]});
    chk(cfg.regulation_voltage_target, 3600 + 10 * sh[1][6:0]);
    chk(cfg.fast_charge_current_code, sh[2]);
    chk(cfg.programmed_charge_current, sh[2] * st);
    chk(cfg.current_step_select, sh[3][7]);
    chk(cfg.precharge_current_code, sh[3][4:0]);
    chk(cfg.precharge_current, sh[3][4:0] * st);
    chk(cfg.termination_percent_code, sh[4][5:1]);
    chk(cfg.termination_disable, sh[4][0]);
  endtask

  task automatic chk_reg(int k);
    u_ccm_i2c_host.rd(OFF[k], rv, ok);
    chk(ok, 1);
    chk(rv, sh[k]);
  endtask

  // One event with a given mask; the flag must set either way
  task automatic evt_case(int i, logic [7:0] m);
    int p;
    p = (i >= 3) ? i + 1 : i;
    u_ccm_i2c_host.wr(7'h2A, 8'h0A, m, ok);
    sh[0] = m;
    @(negedge clk);
    evt = ccm_evt_t'(6'b1 << i);
    @(negedge clk);
    evt = '0;
    repeat (2) @(negedge clk);
    chk(irq, !m[p]);
    chk(cfg.button_wake_first_flag, p == 2);
    u_ccm_i2c_host.rd(8'h06, rv, ok);
    chk(rv, 8'h01 << p);
    chk(irq, 0);
    chk(cfg.button_wake_first_flag, 0);
    u_ccm_i2c_host.rd(8'h06, rv, ok);
    chk(rv, 0);
  endtask

  task automatic summarize();
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    int         k;
    logic [7:0] d, r;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk(irq, 0);
    for (int j = 0; j < 5; j++)
    begin
      chk_reg(j);
    end
    chk_cfg();
    u_ccm_i2c_host.rd(8'h20, rv, ok);
    chk(rv, 0);
    u_ccm_i2c_host.wr(7'h2B, 8'h12, 8'h11, ok);
    chk(ok, 0);
    // Ceiling corner codes first, then random traffic
    for (int t = 0; t < 16; t++)
    begin
      k = (t < 3) ? 1 : $unsigned($random(seed)) % 5;
      d = $random(seed);
      d = (t == 0) ? 8'h64 : (t == 1) ? 8'h65 : (t == 2) ? 8'hFF : d;
      if (k == 4 && d[5:1] == 5'h00)
        d[1] = 1'b1;
      u_ccm_i2c_host.wr(7'h2A, OFF[k], d, ok);
      chk(ok, 1);
      sh[k] = stored(k, d);
      chk_reg(k);
      chk_cfg();
    end
    for (int i = 0; i < 6; i++)
    begin
      r = $random(seed);
      evt_case(i, r);
      evt_case(i, ~r);
    end
    // A reset in mid-run must restore every register
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    sh = '{8'h00, 8'h3C, 8'h08, 8'h02, 8'h14};
    repeat (4) @(negedge clk);
    chk(irq, 0);
    u_ccm_i2c_host.rd2(8'h12, d, r, ok);
    chk(ok, 1);
    chk(d, sh[1]);
    chk(r, sh[2]);
    chk_cfg();
    u_ccm_i2c_host.wr2(8'h14, 8'h9F, 8'h3F, ok);
    chk(ok, 1);
    sh[3] = 8'h9F;
    sh[4] = 8'h3F;
    for (int j = 0; j < 5; j++)
    begin
      chk_reg(j);
    end
    chk_cfg();
    summarize();
  end

  initial
  begin
    #(3000000);
    n_fail++;
    summarize();
  end
endmodule

`default_nettype wire
